// [rtl/switch_gc_pkg.sv]
// shared constants and types of the global switch control register bank
package switch_gc_pkg;

   // printed offsets are register indices; byte address is index times four
   localparam logic [5:0] REG_IDX_P3       = 6'h06;
   localparam logic [5:0] REG_IDX_STORM_LO = 6'h07;
   localparam logic [5:0] REG_IDX_FT_A     = 6'h08;
   localparam logic [5:0] REG_IDX_FT_B     = 6'h09;
   localparam logic [5:0] REG_IDX_FT_C     = 6'h0A;
   localparam logic [5:0] REG_IDX_CLK      = 6'h0B;

   localparam int DUPLEX_BIT  = 6;
   localparam int FLOWCTL_BIT = 5;
   localparam int SPEED_BIT   = 4;
   localparam int NULLVID_BIT = 3;
   localparam int STORM_HI_W  = 3;
   localparam int STORM_W     = 11;
   localparam int CLKSEL_LSB  = 6;

   localparam logic              DUPLEX_RST      = 1'b0;
   localparam logic              FLOWCTL_RST     = 1'b1;
   localparam logic              SPEED_RST       = 1'b0;
   localparam logic [STORM_W-1:0] STORM_LIMIT_RST = 11'h063;
   localparam logic [7:0]        FACTORY_A       = 8'h00;
   localparam logic [7:0]        FACTORY_B       = 8'h24;
   localparam logic [7:0]        FACTORY_C       = 8'h35;
   localparam logic [1:0]        CLKSEL_RST      = 2'h2;
   localparam logic [7:0]        CLKREG_RSVD     = 8'h08;

   // cpu interface clock codes: 31.25, 62.5 and 125 MHz
   localparam logic [1:0] CLKSEL_31M25 = 2'h0;
   localparam logic [1:0] CLKSEL_62M5  = 2'h1;
   localparam logic [1:0] CLKSEL_125M  = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int CLK_PERIOD_NS   = 4;
   localparam int STORM_P100_MS   = 67;
   localparam int STORM_P10_MS    = 500;
   localparam int STORM_P100_CYC  = STORM_P100_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STORM_P10_CYC   = STORM_P10_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STORM_CNT_W     = 27;

   localparam logic [1:0]      STRAP_WAIT  = 2'h3;
   localparam logic [3:0][3:0] CREDIT_INIT = {4'h8, 4'h4, 4'h2, 4'h1};

   typedef struct packed {
      logic half_duplex;
      logic flow_ctrl_en;
      logic speed_10;
      logic null_vid_replace;
   } port3_cfg_s;

   typedef struct packed {
      logic duplex;
      logic flow_ctrl;
      logic speed_10;
   } strap_s;

endpackage

// [rtl/strap_sync.sv]
// strap pin synchroniser with a single load pulse after reset release
module strap_sync
   import switch_gc_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire strap_s pins,
   output strap_s      strap_val,
   output logic        strap_load
);

   typedef struct packed {
      strap_s     s1;
      strap_s     s2;
      logic [1:0] cnt;
      logic       load;
   } sync_s;

   sync_s s_reg;
   sync_s s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.s1 = pins;
      s_next.s2 = s_reg.s1;
      s_next.load = 1'b0;
      // wait until the second stage holds a sampled pin level
      if (s_reg.cnt != STRAP_WAIT)
      begin
         s_next.cnt = s_reg.cnt + 2'h1;
         s_next.load = (s_reg.cnt == STRAP_WAIT - 2'h1);
      end
      if (!aresetn)
         s_next = '0;
   end

   always_ff @(posedge aclk)
      s_reg <= s_next;

   assign strap_val  = s_reg.s2;
   assign strap_load = s_reg.load;

   a_load_single: assert property (@(posedge aclk) disable iff (!aresetn)
      strap_load |=> !strap_load [*3]) else $error("strap load repeated");

endmodule

// [rtl/storm_limiter.sv]
// per-port broadcast block counter over a speed dependent period
module storm_limiter
   import switch_gc_pkg::*;
#(
   parameter int P100_CYC = STORM_P100_CYC,
   parameter int P10_CYC  = STORM_P10_CYC
)(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               speed_10,
   input  wire logic               block_seen,
   input  wire logic [STORM_W-1:0] limit,
   output logic                    drop
);

   typedef struct packed {
      logic [STORM_CNT_W-1:0] cnt;
      logic [STORM_W-1:0]     blocks;
      logic                   drop;
   } lim_s;

   lim_s s_reg;
   lim_s s_next;
   logic period_end;

   always_comb
   begin
      s_next = s_reg;
      period_end = s_reg.cnt >= (speed_10 ? STORM_CNT_W'(P10_CYC - 1) : STORM_CNT_W'(P100_CYC - 1));
      if (period_end)
      begin
         s_next.cnt = '0;
         s_next.blocks = STORM_W'(block_seen);
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 1'b1;
         // saturate so a long storm cannot wrap the count below the limit
         if (block_seen && s_reg.blocks != '1)
            s_next.blocks = s_reg.blocks + 1'b1;
      end
      s_next.drop = (s_next.blocks >= limit);
      if (!aresetn)
         s_next = '0;
   end

   always_ff @(posedge aclk)
      s_reg <= s_next;

   assign drop = s_reg.drop;

   a_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (!speed_10 && s_reg.cnt == STORM_CNT_W'(P100_CYC - 1)) |=> s_reg.cnt == '0) else $error("period not ended");
   a_drop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (drop && !period_end && $stable(limit)) |=> drop) else $error("drop released mid period");

endmodule

// [rtl/switch_global_control_regs.sv]
// global switch control register bank with axi4-lite slave and its controlled logic
// How it works
// - port 3 mii runs half duplex when the duplex bit is one and full duplex when zero.
// - the duplex bit is loaded from the duplex strap pin after reset, low meaning full duplex.
// - the port 3 flow control bit enables or disables full duplex flow control on that mii.
// - the flow control bit is loaded from its strap pin after reset, defaulting to enabled.
// - the port 3 speed bit selects 10 Mbps when one and 100 Mbps when zero.
// - the speed bit is loaded from the third port speed strap after reset, defaulting to 100 Mbps.
// - with null vid replacement set, a zero vlan id is replaced by the 12-bit port vlan id.
// - the 11-bit storm limit takes its top three bits from register 6 and its low byte from register 7.
// - each input port is limited to that many 64-byte blocks per 67 ms at 100 Mbps or 500 ms at 10 Mbps.
// - the storm limit resets to 0x063.
// - three read-only test registers read 0x00, 0x24 and 0x35 and software must not change them.
// - clock select code 00 picks 31.25 MHz and code 01 picks 62.5 MHz for the cpu interface.
// - clock select code 10 picks 125 MHz and is the reset value.
// - with weighted fair queueing on and all queues busy, queues 3 to 0 share bandwidth 8:4:2:1.
module switch_global_control_regs
   import switch_gc_pkg::*;
#(
   parameter int NUM_PORTS      = 3,
   parameter int PERIOD_100_CYC = STORM_P100_CYC,
   parameter int PERIOD_10_CYC  = STORM_P10_CYC
)(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire logic [7:0]           araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   input  wire logic                 duplex_strap_pin,
   input  wire logic                 flow_ctrl_strap_pin,
   input  wire logic                 third_port_speed_strap,
   output port3_cfg_s                port3_cfg,
   input  wire logic [11:0]          frame_vid,
   input  wire logic [11:0]          port_vid,
   output logic [11:0]               vid_out,
   input  wire logic [NUM_PORTS-1:0] port_speed_10,
   input  wire logic [NUM_PORTS-1:0] bcast_block,
   output logic [NUM_PORTS-1:0]      bcast_drop,
   output logic [STORM_W-1:0]        storm_limit,
   output logic [1:0]                cpu_if_clk_sel,
   input  wire logic                 wfq_enable,
   input  wire logic [3:0]           queue_busy,
   input  wire logic                 queue_tx_done,
   output logic [1:0]                queue_grant,
   output logic                      grant_valid
);

   typedef struct packed {
      logic               aw_got;
      logic [5:0]         aw_idx;
      logic               w_got;
      logic [7:0]         w_byte;
      logic               w_lane0;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [7:0]         rdata;
      port3_cfg_s         cfg;
      logic [STORM_W-1:0] storm;
      logic [1:0]         clksel;
      logic [11:0]        vid;
      logic [3:0][3:0]    credit;
      logic [1:0]         grant;
      logic               gvalid;
   } ctrl_s;

   ctrl_s  s_reg;
   ctrl_s  s_next;
   strap_s strap_val;
   logic   strap_load;
   logic   wr_go;
   logic   [3:0][3:0] cr;

   function automatic logic reg_known(input logic [5:0] idx);
      reg_known = (idx >= REG_IDX_P3) && (idx <= REG_IDX_CLK);
   endfunction

   function automatic logic [7:0] rd_value(input logic [5:0] idx, input ctrl_s s);
      case (idx)
         REG_IDX_P3:       rd_value = {1'b0, s.cfg.half_duplex, s.cfg.flow_ctrl_en, s.cfg.speed_10,
                                       s.cfg.null_vid_replace, s.storm[STORM_W-1 -: STORM_HI_W]};
         REG_IDX_STORM_LO: rd_value = s.storm[7:0];
         REG_IDX_FT_A:     rd_value = FACTORY_A;
         REG_IDX_FT_B:     rd_value = FACTORY_B;
         REG_IDX_FT_C:     rd_value = FACTORY_C;
         REG_IDX_CLK:      rd_value = CLKREG_RSVD | {s.clksel, 6'h00};
         default:          rd_value = 8'h00;
      endcase
   endfunction

   // strict priority when fair queueing is off; otherwise only queues with credit left
   function automatic logic [1:0] pick(input logic [3:0] busy, input logic [3:0][3:0] c, input logic fair);
      pick = 2'h0;
      for (int i = 0; i < 4; i++)
         if (busy[i] && (!fair || c[i] != 4'h0))
            pick = 2'(i);
   endfunction

   function automatic logic has_credit(input logic [3:0] busy, input logic [3:0][3:0] c);
      has_credit = 1'b0;
      for (int i = 0; i < 4; i++)
         if (busy[i] && c[i] != 4'h0)
            has_credit = 1'b1;
   endfunction

   strap_sync u_straps (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pins       ({duplex_strap_pin, flow_ctrl_strap_pin, third_port_speed_strap}),
      .strap_val  (strap_val),
      .strap_load (strap_load)
   );

   assign wr_go   = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
   assign awready = ~s_reg.aw_got & ~s_reg.bvalid;
   assign wready  = ~s_reg.w_got & ~s_reg.bvalid;
   assign arready = ~s_reg.rvalid;

   always_comb
   begin
      s_next = s_reg;
      cr = s_reg.credit;
      // write channel: address and data may arrive in either order
      if (awvalid && awready)
      begin
         s_next.aw_got = 1'b1;
         s_next.aw_idx = awaddr[7:2];
      end
      if (wvalid && wready)
      begin
         s_next.w_got = 1'b1;
         s_next.w_byte = wdata[7:0];
         s_next.w_lane0 = wstrb[0];
      end
      if (s_reg.bvalid && bready)
         s_next.bvalid = 1'b0;
      if (wr_go)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = reg_known(s_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         // only byte lane 0 carries register data; test registers ignore writes
         if (s_reg.w_lane0)
         begin
            case (s_reg.aw_idx)
               REG_IDX_P3:
               begin
                  s_next.cfg.half_duplex = s_reg.w_byte[DUPLEX_BIT];
                  s_next.cfg.flow_ctrl_en = s_reg.w_byte[FLOWCTL_BIT];
                  s_next.cfg.speed_10 = s_reg.w_byte[SPEED_BIT];
                  s_next.cfg.null_vid_replace = s_reg.w_byte[NULLVID_BIT];
                  s_next.storm[STORM_W-1 -: STORM_HI_W] = s_reg.w_byte[STORM_HI_W-1:0];
               end
               REG_IDX_STORM_LO: s_next.storm[7:0] = s_reg.w_byte;
               REG_IDX_CLK:      s_next.clksel = s_reg.w_byte[CLKSEL_LSB +: 2];
               default:          ;
            endcase
         end
      end
      // read channel: one cycle from address to data
      if (s_reg.rvalid && rready)
         s_next.rvalid = 1'b0;
      if (arvalid && arready)
      begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_value(araddr[7:2], s_reg);
         s_next.rresp = reg_known(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      // strap capture overrides the duplex, flow control and speed bits of a write landing in the same cycle
      if (strap_load)
      begin
         s_next.cfg.half_duplex = strap_val.duplex;
         s_next.cfg.flow_ctrl_en = strap_val.flow_ctrl;
         s_next.cfg.speed_10 = strap_val.speed_10;
      end
      s_next.vid = (s_reg.cfg.null_vid_replace && frame_vid == 12'h000) ? port_vid : frame_vid;
      // credits are spent per packet and refilled once no busy queue has any left
      s_next.gvalid = |queue_busy;
      s_next.grant = pick(queue_busy, s_reg.credit, wfq_enable);
      if (queue_tx_done && s_reg.gvalid && wfq_enable && cr[s_reg.grant] != 4'h0)
         cr[s_reg.grant] = cr[s_reg.grant] - 4'h1;
      if (!has_credit(queue_busy, cr))
         cr = CREDIT_INIT;
      s_next.credit = cr;
      if (!aresetn)
      begin
         s_next = '0;
         s_next.cfg.half_duplex = DUPLEX_RST;
         s_next.cfg.flow_ctrl_en = FLOWCTL_RST;
         s_next.cfg.speed_10 = SPEED_RST;
         s_next.storm = STORM_LIMIT_RST;
         s_next.clksel = CLKSEL_RST;
         s_next.credit = CREDIT_INIT;
      end
   end

   always_ff @(posedge aclk)
      s_reg <= s_next;

   generate
      for (genvar g = 0; g < NUM_PORTS; g++)
      begin : g_storm
         logic speed_sel;
         // the last port is port 3, whose speed is set here rather than by a phy
         assign speed_sel = (g == NUM_PORTS - 1) ? s_reg.cfg.speed_10 : port_speed_10[g];
         storm_limiter #(
            .P100_CYC (PERIOD_100_CYC),
            .P10_CYC  (PERIOD_10_CYC)
         ) u_limiter (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .speed_10   (speed_sel),
            .block_seen (bcast_block[g]),
            .limit      (s_reg.storm),
            .drop       (bcast_drop[g])
         );
      end
   endgenerate

   assign bresp          = s_reg.bresp;
   assign bvalid         = s_reg.bvalid;
   assign rdata          = {24'h000000, s_reg.rdata};
   assign rresp          = s_reg.rresp;
   assign rvalid         = s_reg.rvalid;
   assign port3_cfg      = s_reg.cfg;
   assign vid_out        = s_reg.vid;
   assign storm_limit    = s_reg.storm;
   assign cpu_if_clk_sel = s_reg.clksel;
   assign queue_grant    = s_reg.grant;
   assign grant_valid    = s_reg.gvalid;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence p3_write;
      wr_go && s_reg.w_lane0 && s_reg.aw_idx == REG_IDX_P3 && !strap_load;
   endsequence

   sequence lo_write;
      wr_go && s_reg.w_lane0 && s_reg.aw_idx == REG_IDX_STORM_LO;
   endsequence

   sequence clk_write;
      wr_go && s_reg.w_lane0 && s_reg.aw_idx == REG_IDX_CLK;
   endsequence

   // a test register write must leave every register field alone
   sequence ro_write;
      wr_go && s_reg.aw_idx >= REG_IDX_FT_A && s_reg.aw_idx <= REG_IDX_FT_C && !strap_load;
   endsequence

   sequence rd_take(logic [5:0] idx);
      arvalid && arready && araddr[7:2] == idx;
   endsequence

   a_duplex_write: assert property
      (p3_write |=> bvalid && port3_cfg.half_duplex == $past(s_reg.w_byte[6]))
      else $error("duplex bit not written");
   a_flow_write: assert property
      (p3_write |=> port3_cfg.flow_ctrl_en == $past(s_reg.w_byte[5]))
      else $error("flow control bit not written");
   a_speed_write: assert property
      (p3_write |=> g_storm[NUM_PORTS-1].speed_sel == $past(s_reg.w_byte[4]))
      else $error("speed not steering port 3");
   a_nullvid_sub: assert property
      ((port3_cfg.null_vid_replace && frame_vid == 12'h000) |=> vid_out == $past(port_vid))
      else $error("null vid not replaced");
   a_nullvid_write: assert property
      (p3_write |=> port3_cfg.null_vid_replace == $past(s_reg.w_byte[3]))
      else $error("null vid bit not written");
   a_vid_keep: assert property
      ((!port3_cfg.null_vid_replace || frame_vid != 12'h000) |=> vid_out == $past(frame_vid))
      else $error("vlan id changed without replacement");
   a_strap_duplex: assert property
      (strap_load |=> port3_cfg.half_duplex == $past(strap_val.duplex))
      else $error("duplex strap not loaded");
   a_strap_flow: assert property
      (strap_load |=> port3_cfg.flow_ctrl_en == $past(strap_val.flow_ctrl))
      else $error("flow strap not loaded");
   a_strap_speed: assert property
      (strap_load |=> port3_cfg.speed_10 == $past(strap_val.speed_10))
      else $error("speed strap not loaded");
   a_storm_low: assert property
      (lo_write |=> storm_limit[7:0] == $past(s_reg.w_byte) && $stable(storm_limit[10:8]))
      else $error("storm low byte not written");
   a_storm_high: assert property
      (p3_write |=> storm_limit[10:8] == $past(s_reg.w_byte[2:0]))
      else $error("storm high bits not written");
   a_p3_readback: assert property
      (rd_take(REG_IDX_P3) |=> rdata == {25'h0, $past(port3_cfg), $past(storm_limit[10:8])})
      else $error("port 3 register read wrong");
   a_storm_lo_read: assert property
      (rd_take(REG_IDX_STORM_LO) |=> rdata == {24'h000000, $past(storm_limit[7:0])})
      else $error("storm low byte read wrong");
   a_storm_reset: assert property
      (!$past(aresetn) |-> storm_limit == STORM_LIMIT_RST)
      else $error("storm limit reset wrong");
   a_factory_read: assert property
      ((arvalid && arready && araddr[7:2] == REG_IDX_FT_B) |=> rvalid && rdata == 32'h00000024)
      else $error("test register value wrong");
   a_factory_c_read: assert property
      (rd_take(REG_IDX_FT_C) |=> rvalid && rdata == 32'h00000035)
      else $error("test register c value wrong");
   a_ro_ignored: assert property
      (ro_write |=> $stable(port3_cfg) && $stable(storm_limit) && $stable(cpu_if_clk_sel))
      else $error("test register write changed a field");
   a_clksel_write: assert property
      (clk_write |=> cpu_if_clk_sel == $past(s_reg.w_byte[7:6]))
      else $error("clock select not written");
   a_clksel_hold: assert property
      (!(wr_go && s_reg.w_lane0 && s_reg.aw_idx == REG_IDX_CLK) |=> $stable(cpu_if_clk_sel))
      else $error("clock select changed without a write");
   a_clksel_reset: assert property
      (!$past(aresetn) |-> cpu_if_clk_sel == CLKSEL_RST)
      else $error("clock select reset wrong");
   a_clksel_read: assert property
      (rd_take(REG_IDX_CLK) |=> rdata == {24'h000000, $past(cpu_if_clk_sel), 6'h08})
      else $error("clock select register read wrong");
   a_wfq_top: assert property
      ((wfq_enable && queue_busy == 4'hF && s_reg.credit[3] != 4'h0) |=> queue_grant == 2'h3)
      else $error("top queue not granted");
   a_wfq_next: assert property
      ((wfq_enable && &queue_busy && s_reg.credit[3] == 4'h0 && s_reg.credit[2] != 4'h0) |=> queue_grant == 2'h2)
      else $error("spent top queue still granted");
   a_grant_valid: assert property
      (1'b1 |=> grant_valid == |$past(queue_busy))
      else $error("grant valid does not follow busy queues");

endmodule

// [bench/mac_port3_model.sv]
// port 3 side partner: broadcast block pulses and vlan ids seen by the switch
module mac_port3_model
(
   input  wire logic   aclk,
   output logic [2:0]  bcast_block,
   output logic [2:0]  port_speed_10,
   output logic [11:0] frame_vid,
   output logic [11:0] port_vid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      bcast_block   = 3'h0;
      port_speed_10 = 3'h0;
      frame_vid     = 12'h000;
      port_vid      = 12'h000;
   end

   // one-cycle pulse per 64-byte block, with a gap so the switch sees each one apart
   task automatic send_blocks(input int port, input int n);
      repeat (n)
      begin
         @(posedge aclk);
         bcast_block <= 3'h1 << port;
         @(posedge aclk);
         bcast_block <= 3'h0;
      end
   endtask

   task automatic set_speed(input logic [2:0] s);
      @(posedge aclk);
      port_speed_10 <= s;
   endtask

   task automatic set_vid(input logic [11:0] f, input logic [11:0] p);
      @(posedge aclk);
      frame_vid <= f;
      port_vid  <= p;
   endtask
endmodule

// [bench/tb.sv]
// self-checking bench of the global switch control register bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import switch_gc_pkg::*;

   // short storm periods keep the run small; the drop tests wait past the end of a whole period
   localparam int P100 = 3000;
   localparam int P10  = 6000;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, grant_valid;
   logic [1:0]  bresp, rresp, cpu_if_clk_sel, queue_grant;
   logic [31:0] rdata;
   logic        dup_pin = 1'b0, flow_pin = 1'b1, spd_pin = 1'b0;
   port3_cfg_s  port3_cfg;
   logic [11:0] frame_vid, port_vid, vid_out;
   logic [2:0]  port_speed_10, bcast_block, bcast_drop;
   logic [10:0] storm_limit;
   logic        wfq_enable = 1'b0, queue_tx_done = 1'b0;
   logic [3:0]  queue_busy = 4'h0;
   int          num_errors = 0, n_tests = 0;
   int          i, j;
   int          cnt [4];

   always #2 aclk = ~aclk;

   switch_global_control_regs #(.NUM_PORTS(3), .PERIOD_100_CYC(P100), .PERIOD_10_CYC(P10))
      switch_global_control_regs_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .duplex_strap_pin(dup_pin),
      .flow_ctrl_strap_pin(flow_pin), .third_port_speed_strap(spd_pin), .port3_cfg(port3_cfg),
      .frame_vid(frame_vid), .port_vid(port_vid), .vid_out(vid_out), .port_speed_10(port_speed_10),
      .bcast_block(bcast_block), .bcast_drop(bcast_drop), .storm_limit(storm_limit),
      .cpu_if_clk_sel(cpu_if_clk_sel), .wfq_enable(wfq_enable), .queue_busy(queue_busy),
      .queue_tx_done(queue_tx_done), .queue_grant(queue_grant), .grant_valid(grant_valid));

   mac_port3_model mac_port3_model_inst (.aclk(aclk), .bcast_block(bcast_block),
      .port_speed_10(port_speed_10), .frame_vid(frame_vid), .port_vid(port_vid));

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic timeout();
      num_errors++;
      finish_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (k = 0; k < 64; k++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (k == 64) timeout();
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (k = 0; k < 64; k++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (k == 64) timeout();
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      axi_write(a, d, r);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // straps are pin levels, so they are set before reset and held
   task automatic do_reset(input logic d, input logic f, input logic s);
      dup_pin  <= d;
      flow_pin <= f;
      spd_pin  <= s;
      aresetn  <= 1'b0;
      tick(16);
      aresetn  <= 1'b1;
      tick(8);
   endtask

   initial
   begin
      do_reset(1'b0, 1'b1, 1'b0);
      rd_chk(8'h18, 32'h20, RESP_OKAY);
      rd_chk(8'h1C, 32'h63, RESP_OKAY);
      rd_chk(8'h20, 32'h00, RESP_OKAY);
      rd_chk(8'h24, 32'h24, RESP_OKAY);
      rd_chk(8'h28, 32'h35, RESP_OKAY);
      rd_chk(8'h2C, 32'h88, RESP_OKAY);
      chk({28'h0, port3_cfg}, 32'h4);
      chk({21'h0, storm_limit}, 32'h063);
      chk({30'h0, cpu_if_clk_sel}, 32'h2);
      wr_chk(8'h1C, 32'h03, RESP_OKAY);
      chk({21'h0, storm_limit}, 32'h003);
      mac_port3_model_inst.send_blocks(0, 2);
      tick(2);
      chk({29'h0, bcast_drop}, 32'h0);
      mac_port3_model_inst.send_blocks(0, 1);
      tick(2);
      chk({29'h0, bcast_drop}, 32'h1);
      for (i = 0; i < P100 + 100 && bcast_drop[0] !== 1'b0; i++) tick(1);
      chk({29'h0, bcast_drop}, 32'h0);
      // port 1 at 10 Mbps keeps its block count past the 100 Mbps period
      mac_port3_model_inst.set_speed(3'h2);
      mac_port3_model_inst.send_blocks(1, 3);
      tick(P100 + 100);
      chk({29'h0, bcast_drop}, 32'h2);
      for (i = 0; i < P10 && bcast_drop[1] !== 1'b0; i++) tick(1);
      chk({29'h0, bcast_drop}, 32'h0);
      wr_chk(8'h20, 32'hFF, RESP_OKAY);
      wr_chk(8'h24, 32'hFF, RESP_OKAY);
      wr_chk(8'h28, 32'hFF, RESP_OKAY);
      rd_chk(8'h20, 32'h00, RESP_OKAY);
      rd_chk(8'h24, 32'h24, RESP_OKAY);
      rd_chk(8'h28, 32'h35, RESP_OKAY);
      wr_chk(8'h30, 32'h55, RESP_SLVERR);
      rd_chk(8'h14, 32'h00, RESP_SLVERR);
      wr_chk(8'h18, 32'hFD, RESP_OKAY);
      rd_chk(8'h18, 32'h7D, RESP_OKAY);
      chk({28'h0, port3_cfg}, 32'hF);
      chk({21'h0, storm_limit}, 32'h503);
      mac_port3_model_inst.set_vid(12'h000, 12'hABC);
      tick(2);
      chk({20'h0, vid_out}, 32'hABC);
      mac_port3_model_inst.set_vid(12'h123, 12'hABC);
      tick(2);
      chk({20'h0, vid_out}, 32'h123);
      wr_chk(8'h18, 32'h00, RESP_OKAY);
      chk({28'h0, port3_cfg}, 32'h0);
      mac_port3_model_inst.set_vid(12'h000, 12'hABC);
      tick(2);
      chk({20'h0, vid_out}, 32'h000);
      // ends on code 00, the low power choice when the host link is slow
      for (i = 2; i >= 0; i--)
      begin
         wr_chk(8'h2C, {24'h0, i[1:0], 6'h00}, RESP_OKAY);
         rd_chk(8'h2C, {24'h0, i[1:0], 6'h08}, RESP_OKAY);
         chk({30'h0, cpu_if_clk_sel}, {30'h0, i[1:0]});
      end
      queue_busy <= 4'hF;
      wfq_enable <= 1'b1;
      tick(3);
      chk({29'h0, grant_valid, queue_grant}, 32'h7);
      for (i = 0; i < 15; i++)
      begin
         queue_tx_done <= 1'b1;
         tick(1);
         cnt[queue_grant]++;
         queue_tx_done <= 1'b0;
         tick(2);
      end
      for (j = 0; j < 4; j++) chk(cnt[j], 32'h1 << j);
      do_reset(1'b1, 1'b0, 1'b1);
      rd_chk(8'h18, 32'h50, RESP_OKAY);
      chk({28'h0, port3_cfg}, 32'hA);
      finish_test();
   end
endmodule
